//--- src/dbr_pkg.sv
// package of offsets, fields and carriers for the acquisition register decode
package dbr_pkg;

    // bridge control word, local offset and fields
    localparam logic [7:0] DBR_BRIDGE_CTRL_OFS = 8'h50;
    localparam int DBR_GP_ENABLE_BIT = 0;
    localparam int DBR_GP_DIR_BIT = 1;
    localparam int DBR_GP_LEVEL_BIT = 2;
    localparam logic [31:0] DBR_BRIDGE_CTRL_RST = 32'h0000_0001;

    // general region byte offsets
    localparam logic [2:0] DBR_RES_LOW_OFS = 3'h0;
    localparam logic [2:0] DBR_RES_HIGH_OFS = 3'h1;
    localparam logic [2:0] DBR_STAT_CTRL_OFS = 3'h2;
    localparam logic [2:0] DBR_UNUSED_OFS = 3'h3;
    localparam logic [2:0] DBR_TMR0_OFS = 3'h4;
    localparam logic [2:0] DBR_TMR1_OFS = 3'h5;
    localparam logic [2:0] DBR_TMR2_OFS = 3'h6;
    localparam logic [2:0] DBR_TMR_CTRL_OFS = 3'h7;

    // status byte fields
    localparam int DBR_ST_BUSY_BIT = 7;
    localparam int DBR_ST_DIN_LSB = 4;
    localparam int DBR_ST_IRQ_BIT = 3;
    // control byte fields
    localparam int DBR_CT_DOUT_LSB = 4;
    localparam int DBR_CT_GATE_BIT = 3;
    localparam int DBR_CT_CHAN_LSB = 0;
    localparam logic [7:0] DBR_CTRL_RST = 8'h00;

    // values read where nothing is mapped
    localparam logic [7:0] DBR_UNUSED_READ = 8'h00;
    localparam logic [31:0] DBR_BRIDGE_UNMAPPED_READ = 32'h0000_0000;

    // converter timing: 10 us conversion at 50 MHz
    localparam int DBR_CLK_MHZ = 50;
    localparam int DBR_CONV_TIME_US = 10;
    localparam int DBR_CONV_CYCLES = DBR_CONV_TIME_US * DBR_CLK_MHZ;
    localparam int DBR_CONV_SHORT_CYCLES = DBR_CONV_CYCLES / 2;

    // conversion request kinds
    typedef enum logic [1:0] {
        DBR_CONV_NONE = 2'b00,
        DBR_CONV_SHORT = 2'b01,
        DBR_CONV_FULL = 2'b10
    } dbr_conv_t;

    // host i/o access to the general region
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dbr_gen_req_t;

    // host i/o access to the bridge region
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dbr_brg_req_t;

    // byte access to the external timer-counter device
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } dbr_tmr_req_t;

endpackage : dbr_pkg

//--- src/dbr_conv_seq.sv
// conversion sequencer: busy flag and result capture
`timescale 1ns/1ns
`default_nettype none
module dbr_conv_seq (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // start request and sample from converter
    input wire dbr_pkg::dbr_conv_t start_i,
    input wire logic [11:0] sample_i,
    // state
    output logic busy_o,
    output logic [11:0] result_o
);
    import dbr_pkg::*;

    localparam int CW = $clog2(DBR_CONV_CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic short_q;

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            short_q <= 1'b0;
        end else if (start_i == DBR_CONV_FULL) begin
            cnt_q <= CW'(DBR_CONV_CYCLES);
            short_q <= 1'b0;
        end else if (start_i == DBR_CONV_SHORT) begin
            cnt_q <= CW'(DBR_CONV_SHORT_CYCLES);
            short_q <= 1'b1;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
        end
    end

    // busy until count runs out
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            busy_o <= 1'b0;
        end else if (start_i != DBR_CONV_NONE) begin
            busy_o <= 1'b1;
        end else if (cnt_q == CW'(1)) begin
            busy_o <= 1'b0;
        end
    end

    // short conversion keeps top 8 bits only
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result_o <= 12'h000;
        end else if (busy_o && cnt_q == CW'(1)) begin
            result_o <= short_q ? {sample_i[11:4], 4'h0} : sample_i;
        end
    end
endmodule : dbr_conv_seq
`default_nettype wire

//--- src/dbr_irq_latch.sv
// interrupt latch with source select and edge detect
`timescale 1ns/1ns
`default_nettype none
module dbr_irq_latch (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // sources, already synchronised
    input wire logic user_irq_i,
    input wire logic tmr2_out_i,
    input wire logic sel_tmr2_i,
    // host clear
    input wire logic clear_i,
    // latched flag
    output logic flag_o
);
    logic src;
    logic src_q;

    assign src = sel_tmr2_i ? tmr2_out_i : user_irq_i; // [RULE7]

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            src_q <= 1'b0;
        end else begin
            src_q <= src;
        end
    end

    // set wins over clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            flag_o <= 1'b0;
        end else if (src && !src_q) begin
            flag_o <= 1'b1; // [RULE15]
        end else if (clear_i) begin
            flag_o <= 1'b0; // [RULE15]
        end
    end
endmodule : dbr_irq_latch
`default_nettype wire

//--- src/dbr_board_decode.sv
// top register decode of the analog acquisition board
// Summary of operation
// RULE1: all registers decoded in i/o space
// RULE2: two regions, 32-bit bridge, 16-bit general
// RULE3: software discovers region bases at run time
// RULE4: bridge control at 50h, read-modify-write
// RULE5: control bit 0 low enables pin function
// RULE6: control bit 1 high makes pin output
// RULE7: pin level selects user or timer2 irq
// RULE8: general region decodes offsets zero to seven
// RULE9: offset 0 reads low nibble, write starts short
// RULE10: offset 1 reads high byte, write starts full
// RULE11: offset 2 reads status, writes control
// RULE12: offsets 4-6 pass through to counters
// RULE13: offset 3 ignored, 7 writes counter control
// RULE14: busy reads 1 during conversion
// RULE15: irq flag sets on edge, host write clears
// RULE16: counters programmed mode first, then low-high bytes
`timescale 1ns/1ns
`default_nettype none
module dbr_board_decode (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // host i/o accesses, region bases resolved by the bus bridge
    input wire dbr_pkg::dbr_brg_req_t brg_req_i,
    input wire dbr_pkg::dbr_gen_req_t gen_req_i,
    output logic [31:0] brg_rdata_o,
    output logic [15:0] gen_rdata_o,
    output logic brg_rvalid_o,
    output logic gen_rvalid_o,
    // converter
    input wire logic [11:0] adc_sample_i,
    output logic adc_busy_o,
    // connector pins
    input wire logic [2:0] digital_input_bits_i,
    input wire logic user_irq_i,
    output logic [3:0] digital_output_bits_o,
    output logic [2:0] channel_select_o,
    output logic host_irq_o,
    // general-purpose pin of bridge
    output logic latch_source_select_o,
    output logic latch_source_select_oe_o,
    // external timer-counter device
    input wire logic [7:0] tmr_rdata_i,
    input wire logic tmr2_out_i,
    output dbr_pkg::dbr_tmr_req_t tmr_req_o
);
    import dbr_pkg::*;

    logic [31:0] brg_ctrl_q;
    logic [7:0] ctrl_q;
    logic [2:0] din_s1_q;
    logic [2:0] din_s2_q;
    logic uirq_s1_q;
    logic uirq_s2_q;
    logic t2_s1_q;
    logic t2_s2_q;
    logic gen_wr;
    logic gen_rd;
    logic brg_wr;
    logic brg_rd;
    logic stat_wr;
    logic [7:0] gen_byte;
    dbr_conv_t conv_start;
    logic conv_busy;
    logic [11:0] conv_result;
    logic irq_flag;
    logic gp_level;
    logic gp_drive;

    // both regions are i/o windows behind the bridge [RULE1] [RULE3]
    assign gen_wr = gen_req_i.wr;
    assign gen_rd = gen_req_i.rd;
    assign brg_wr = brg_req_i.wr && brg_req_i.addr == DBR_BRIDGE_CTRL_OFS; // [RULE4]
    assign brg_rd = brg_req_i.rd;
    // one strobe shared by control load and irq clear
    assign stat_wr = gen_wr && gen_req_i.addr == DBR_STAT_CTRL_OFS;

    // is the offset a timer data or control port
    function automatic logic is_tmr_port(input logic [2:0] a);
        is_tmr_port = a == DBR_TMR0_OFS || a == DBR_TMR1_OFS
            || a == DBR_TMR2_OFS || a == DBR_TMR_CTRL_OFS;
    endfunction : is_tmr_port

    // pin inputs pass two flops
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            din_s1_q <= 3'h0;
            din_s2_q <= 3'h0;
            uirq_s1_q <= 1'b0;
            uirq_s2_q <= 1'b0;
            t2_s1_q <= 1'b0;
            t2_s2_q <= 1'b0;
        end else begin
            din_s1_q <= digital_input_bits_i;
            din_s2_q <= din_s1_q;
            uirq_s1_q <= user_irq_i;
            uirq_s2_q <= uirq_s1_q;
            t2_s1_q <= tmr2_out_i;
            t2_s2_q <= t2_s1_q;
        end
    end

    // bridge control word, full 32-bit word [RULE2]
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            brg_ctrl_q <= DBR_BRIDGE_CTRL_RST;
        end else if (brg_wr) begin
            brg_ctrl_q <= brg_req_i.wdata; // [RULE4]
        end
    end

    // pin active only when enabled (low) and output (high)
    assign gp_drive = !brg_ctrl_q[DBR_GP_ENABLE_BIT]
        && brg_ctrl_q[DBR_GP_DIR_BIT]; // [RULE5] [RULE6]
    assign gp_level = gp_drive && brg_ctrl_q[DBR_GP_LEVEL_BIT]; // [RULE7]

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            latch_source_select_o <= 1'b0;
            latch_source_select_oe_o <= 1'b0;
        end else begin
            latch_source_select_o <= gp_level;
            latch_source_select_oe_o <= gp_drive; // [RULE6]
        end
    end

    // bridge read answer
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            brg_rdata_o <= 32'h0000_0000;
            brg_rvalid_o <= 1'b0;
        end else begin
            brg_rvalid_o <= brg_rd;
            if (brg_rd) begin
                brg_rdata_o <= (brg_req_i.addr == DBR_BRIDGE_CTRL_OFS)
                    ? brg_ctrl_q : DBR_BRIDGE_UNMAPPED_READ;
            end
        end
    end

    // conversion start on writes to offsets 0 and 1
    always_comb begin
        conv_start = DBR_CONV_NONE;
        if (gen_wr && gen_req_i.addr == DBR_RES_LOW_OFS) begin
            conv_start = DBR_CONV_SHORT; // [RULE9]
        end else if (gen_wr && gen_req_i.addr == DBR_RES_HIGH_OFS) begin
            conv_start = DBR_CONV_FULL; // [RULE10]
        end
    end

    dbr_conv_seq u_conv (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(conv_start),
        .sample_i(adc_sample_i),
        .busy_o(conv_busy),
        .result_o(conv_result)
    );

    // control byte, offset 3 writes fall through [RULE13]
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= DBR_CTRL_RST;
        end else if (stat_wr) begin
            ctrl_q <= gen_req_i.wdata; // [RULE11]
        end
    end

    dbr_irq_latch u_irq (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .user_irq_i(uirq_s2_q),
        .tmr2_out_i(t2_s2_q),
        .sel_tmr2_i(gp_level),
        .clear_i(stat_wr),
        .flag_o(irq_flag)
    );

    // pin-facing outputs
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            digital_output_bits_o <= 4'h0;
            channel_select_o <= 3'h0;
            host_irq_o <= 1'b0;
            adc_busy_o <= 1'b0;
        end else begin
            digital_output_bits_o <= ctrl_q[DBR_CT_DOUT_LSB +: 4];
            channel_select_o <= ctrl_q[DBR_CT_CHAN_LSB +: 3];
            host_irq_o <= irq_flag && ctrl_q[DBR_CT_GATE_BIT];
            adc_busy_o <= conv_busy;
        end
    end

    // timer port pass-through, one cycle request [RULE12]
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tmr_req_o <= '0;
        end else begin
            tmr_req_o.wr <= gen_wr && is_tmr_port(gen_req_i.addr); // [RULE12] [RULE13]
            tmr_req_o.rd <= gen_rd && is_tmr_port(gen_req_i.addr)
                && gen_req_i.addr != DBR_TMR_CTRL_OFS;
            tmr_req_o.sel <= gen_req_i.addr[1:0];
            tmr_req_o.wdata <= gen_req_i.wdata;
        end
    end

    // general read mux over eight offsets [RULE8]
    always_comb begin
        case (gen_req_i.addr)
            DBR_RES_LOW_OFS: gen_byte = {conv_result[3:0], 4'h0}; // [RULE9]
            DBR_RES_HIGH_OFS: gen_byte = conv_result[11:4]; // [RULE10]
            DBR_STAT_CTRL_OFS: gen_byte = {conv_busy, din_s2_q, irq_flag,
                ctrl_q[DBR_CT_CHAN_LSB +: 3]}; // [RULE11] [RULE14]
            DBR_UNUSED_OFS: gen_byte = DBR_UNUSED_READ; // [RULE13]
            DBR_TMR0_OFS: gen_byte = tmr_rdata_i;
            DBR_TMR1_OFS: gen_byte = tmr_rdata_i;
            DBR_TMR2_OFS: gen_byte = tmr_rdata_i;
            default: gen_byte = DBR_UNUSED_READ;
        endcase
    end

    // general read answer, byte in low lane of 16-bit word [RULE2]
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            gen_rdata_o <= 16'h0000;
            gen_rvalid_o <= 1'b0;
        end else begin
            gen_rvalid_o <= gen_rd;
            if (gen_rd) begin
                gen_rdata_o <= {8'h00, gen_byte};
            end
        end
    end
endmodule : dbr_board_decode
`default_nettype wire

//--- dv/dbr_decode_props.sv
// assertion checker for the acquisition register decode
`timescale 1ns/1ns
`default_nettype none
module dbr_decode_props (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // host side
    input wire dbr_pkg::dbr_brg_req_t brg_req_i,
    input wire dbr_pkg::dbr_gen_req_t gen_req_i,
    input wire logic [15:0] gen_rdata_o,
    input wire logic brg_rvalid_o,
    input wire logic gen_rvalid_o,
    // board side
    input wire logic adc_busy_o,
    input wire logic latch_source_select_oe_o,
    input wire dbr_pkg::dbr_tmr_req_t tmr_req_o
);
    import dbr_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence s_ctrl_wr;
        brg_req_i.wr && brg_req_i.addr == DBR_BRIDGE_CTRL_OFS ##1 !brg_req_i.wr;
    endsequence
    chk_gen_answer: assert property (gen_req_i.rd |=> gen_rvalid_o)
        else $error("general read not answered");
    chk_gen_quiet: assert property (!gen_req_i.rd |=> !gen_rvalid_o)
        else $error("general answer without read");
    chk_brg_answer: assert property (brg_req_i.rd |=> brg_rvalid_o)
        else $error("bridge read not answered");
    chk_upper_zero: assert property (gen_rvalid_o |-> gen_rdata_o[15:8] == 8'h00)
        else $error("general upper byte not zero");
    chk_tmr_pass: assert property (gen_req_i.wr && gen_req_i.addr[2] |=> tmr_req_o.wr
        && tmr_req_o.sel == $past(gen_req_i.addr[1:0]) && tmr_req_o.wdata == $past(gen_req_i.wdata))
        else $error("counter write not passed");
    chk_unused_drop: assert property (gen_req_i.wr && gen_req_i.addr == DBR_UNUSED_OFS
        |=> !tmr_req_o.wr) else $error("unused write reached counter");
    chk_ctl_noread: assert property (gen_req_i.rd && gen_req_i.addr == DBR_TMR_CTRL_OFS
        |=> !tmr_req_o.rd) else $error("control port was read");
    chk_busy_start: assert property (gen_req_i.wr && gen_req_i.addr[2:1] == 2'h0
        |-> ##2 adc_busy_o) else $error("busy not raised");
    chk_pin_enable: assert property (s_ctrl_wr |=> latch_source_select_oe_o ==
        ($past(brg_req_i.wdata[1], 2) && !$past(brg_req_i.wdata[0], 2)))
        else $error("pin enable wrong");
endmodule : dbr_decode_props
bind dbr_board_decode dbr_decode_props chk (.core_clk_i, .sys_rst_i, .brg_req_i, .gen_req_i,
    .gen_rdata_o, .brg_rvalid_o, .gen_rvalid_o, .adc_busy_o, .latch_source_select_oe_o,
    .tmr_req_o);
`default_nettype wire

//--- dv/dbr_tmr_model.sv
// timer-counter device model on the far side of the counter port
`timescale 1ns/1ns
`default_nettype none
module dbr_tmr_model (
    // clock and port
    input wire logic core_clk_i,
    input wire dbr_pkg::dbr_tmr_req_t tmr_req_o,
    // returned data and counter 2 output
    output logic [7:0] tmr_rdata_i = 8'h00,
    output logic tmr2_out_i = 1'b0
);
    import dbr_pkg::*;
    // reads return the last data byte loaded
    always @(posedge core_clk_i) begin
        if (tmr_req_o.wr && tmr_req_o.sel != 2'h3) begin
            tmr_rdata_i <= tmr_req_o.wdata;
            if (tmr_req_o.sel == 2'h2) begin
                tmr2_out_i <= tmr_req_o.wdata[0];
            end
        end
    end
endmodule : dbr_tmr_model
`default_nettype wire

//--- dv/test_daq_board_io_register_decode.sv
// self-checking bench of the acquisition register decode
`timescale 1ns/1ns
`default_nettype none
module test_daq_board_io_register_decode;
    import dbr_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i;
    dbr_brg_req_t brg_req_i;
    dbr_gen_req_t gen_req_i;
    logic [31:0] brg_rdata_o;
    logic [15:0] gen_rdata_o;
    logic brg_rvalid_o, gen_rvalid_o, adc_busy_o, user_irq_i, host_irq_o, tmr2_out_i;
    logic [11:0] adc_sample_i;
    logic [2:0] digital_input_bits_i, channel_select_o;
    logic [3:0] digital_output_bits_o;
    logic latch_source_select_o, latch_source_select_oe_o;
    logic [7:0] tmr_rdata_i;
    dbr_tmr_req_t tmr_req_o;
    int miscompares = 0;
    int cmp_count = 0;
    always #10 core_clk_i = ~core_clk_i;
    dbr_board_decode dut (.core_clk_i, .sys_rst_i, .brg_req_i, .gen_req_i, .brg_rdata_o,
        .gen_rdata_o, .brg_rvalid_o, .gen_rvalid_o, .adc_sample_i, .adc_busy_o,
        .digital_input_bits_i, .user_irq_i, .digital_output_bits_o, .channel_select_o,
        .host_irq_o, .latch_source_select_o, .latch_source_select_oe_o, .tmr_rdata_i,
        .tmr2_out_i, .tmr_req_o);
    dbr_tmr_model tmr (.core_clk_i, .tmr_req_o, .tmr_rdata_i, .tmr2_out_i);
    task automatic stop_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : tick
    task automatic gwr(input logic [2:0] a, input logic [7:0] d);
        gen_req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        tick(1);
        gen_req_i.wr = 1'b0;
        // idle cycle keeps back-to-back requests apart
        tick(1);
    endtask : gwr
    task automatic gchk(input logic [2:0] a, input logic [15:0] e);
        gen_req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        tick(1);
        gen_req_i.rd = 1'b0;
        cmp("gen_rvalid_o", 32'h1, 32'(gen_rvalid_o));
        cmp("gen_rdata_o", 32'(e), 32'(gen_rdata_o));
        tick(1);
    endtask : gchk
    task automatic bwr(input logic [7:0] a, input logic [31:0] d);
        brg_req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        tick(1);
        brg_req_i.wr = 1'b0;
        tick(1);
    endtask : bwr
    task automatic bchk(input logic [7:0] a, input logic [31:0] e);
        brg_req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
        tick(1);
        brg_req_i.rd = 1'b0;
        cmp("brg_rvalid_o", 32'h1, 32'(brg_rvalid_o));
        cmp("brg_rdata_o", e, brg_rdata_o);
        tick(1);
    endtask : bchk
    task automatic t_reset();
        bchk(DBR_BRIDGE_CTRL_OFS, DBR_BRIDGE_CTRL_RST);
        bchk(8'h54, DBR_BRIDGE_UNMAPPED_READ);
        cmp("oe", 32'h0, 32'(latch_source_select_oe_o));
        gchk(DBR_UNUSED_OFS, 16'h0000);
        gchk(DBR_TMR_CTRL_OFS, 16'h0000);
        gwr(DBR_UNUSED_OFS, 8'hFF);
        gchk(DBR_STAT_CTRL_OFS, 16'h0050);
    endtask : t_reset
    // busy length counted on the registered busy copy
    task automatic t_conv(input logic [2:0] ofs, input int cyc, input logic [11:0] smp,
        input logic [7:0] lo);
        int n;
        adc_sample_i = smp;
        gwr(ofs, 8'h00);
        gchk(DBR_STAT_CTRL_OFS, 16'h00D0);
        // status read spans two busy cycles
        n = 2;
        while (adc_busy_o === 1'b1 && n < 1000) begin
            n++;
            tick(1);
        end
        cmp("busy cycles", cyc, n);
        if (n >= 1000) stop_test();
        gchk(DBR_STAT_CTRL_OFS, 16'h0050);
        gchk(DBR_RES_HIGH_OFS, {8'h00, smp[11:4]});
        gchk(DBR_RES_LOW_OFS, {8'h00, lo});
    endtask : t_conv
    task automatic t_ctrl();
        digital_input_bits_i = 3'h3;
        gwr(DBR_STAT_CTRL_OFS, 8'hA5);
        tick(1);
        cmp("dout", 32'hA, 32'(digital_output_bits_o));
        cmp("chan", 32'h5, 32'(channel_select_o));
        gchk(DBR_STAT_CTRL_OFS, 16'h0035);
        digital_input_bits_i = 3'h5;
    endtask : t_ctrl
    // flag latches with gate off, host line follows only with gate on
    task automatic t_irq();
        gwr(DBR_STAT_CTRL_OFS, 8'h00);
        user_irq_i = 1'b1;
        tick(8);
        cmp("host_irq_o", 32'h0, 32'(host_irq_o));
        gchk(DBR_STAT_CTRL_OFS, 16'h0058);
        user_irq_i = 1'b0;
        gwr(DBR_STAT_CTRL_OFS, 8'h08);
        user_irq_i = 1'b1;
        tick(8);
        cmp("host_irq_o", 32'h1, 32'(host_irq_o));
        gchk(DBR_STAT_CTRL_OFS, 16'h0058);
        gwr(DBR_STAT_CTRL_OFS, 8'h08);
        tick(2);
        cmp("host_irq_o", 32'h0, 32'(host_irq_o));
        gchk(DBR_STAT_CTRL_OFS, 16'h0050);
        user_irq_i = 1'b0;
    endtask : t_irq
    task automatic t_src();
        bwr(DBR_BRIDGE_CTRL_OFS, 32'h6);
        tick(1);
        cmp("oe", 32'h1, 32'(latch_source_select_oe_o));
        cmp("pin", 32'h1, 32'(latch_source_select_o));
        bwr(8'h60, 32'h1);
        bchk(DBR_BRIDGE_CTRL_OFS, 32'h6);
        gwr(DBR_STAT_CTRL_OFS, 8'h08);
        user_irq_i = 1'b1;
        tick(8);
        cmp("host_irq_o", 32'h0, 32'(host_irq_o));
        user_irq_i = 1'b0;
        gwr(DBR_TMR2_OFS, 8'h01);
        tick(8);
        cmp("host_irq_o", 32'h1, 32'(host_irq_o));
    endtask : t_src
    task automatic t_tmr();
        gwr(DBR_TMR_CTRL_OFS, 8'h34);
        gwr(DBR_TMR0_OFS, 8'h12);
        gwr(DBR_TMR0_OFS, 8'h56);
        gchk(DBR_TMR0_OFS, 16'h0056);
    endtask : t_tmr
    initial begin
        sys_rst_i = 1'b1;
        brg_req_i = '0;
        gen_req_i = '0;
        adc_sample_i = 12'h000;
        digital_input_bits_i = 3'h5;
        user_irq_i = 1'b0;
        tick(3);
        sys_rst_i = 1'b0;
        t_reset();
        t_conv(DBR_RES_HIGH_OFS, DBR_CONV_CYCLES, 12'hA5C, 8'hC0);
        t_conv(DBR_RES_LOW_OFS, DBR_CONV_SHORT_CYCLES, 12'h3E7, 8'h00);
        t_ctrl();
        t_irq();
        t_src();
        t_tmr();
        stop_test();
    end
endmodule : test_daq_board_io_register_decode
`default_nettype wire
